// ===== design/hsos_pkg.sv
// Package for the hard safe-off sequencer: register map, command codes, timing.
// Assumes a 40 MHz system clock; shared by the design and its bench.
package hsos_pkg;
   // Clock rate
   localparam int unsigned CLK_HZ = 40000000;
   // Documented times, in their own units
   localparam int unsigned FILTER_US = 500;       // Glitch rejection, 0.5 ms
   localparam int unsigned SHUTOFF_MS = 20;       // Power removal bound
   localparam int unsigned SKEW_S = 10;           // Channel skew limit
   // Derived cycle counts
   localparam int unsigned FILTER_CYC = (CLK_HZ / 1000000) * FILTER_US;
   localparam int unsigned SHUTOFF_CYC = (CLK_HZ / 1000) * SHUTOFF_MS;
   localparam longint unsigned SKEW_CYC = longint'(CLK_HZ) * SKEW_S;

   // Command codes on the command port
   localparam logic [7:0] CMD_SERVO_ON = 8'h31;
   localparam logic [7:0] CMD_SERVO_OFF = 8'h32;

   // Register offsets
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_WARN = 4'h8;
   localparam logic [3:0] ADDR_BRAKE_DLY = 4'hc;

   // Status field positions
   localparam int unsigned ST_SERVO_ON_BIT = 0;
   localparam int unsigned ST_SAFE_OFF_BIT = 10;
   localparam int unsigned ST_IN_A_BIT = 1;
   localparam int unsigned ST_IN_B_BIT = 2;
   localparam int unsigned ST_SKEW_BIT = 3;
   localparam int unsigned ST_READY_BIT = 4;
   localparam int unsigned ST_UTIL_LOCK_BIT = 5;
   // Control field positions
   localparam int unsigned CT_DB_EN_BIT = 0;
   localparam int unsigned CT_UTIL_RUN_BIT = 1;
   localparam int unsigned CT_MOTION_BIT = 2;
   // Warning field
   localparam int unsigned WN_CMD_BIT = 0;
   localparam int unsigned WN_SKEW_BIT = 1;

   // Reset values
   localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
   localparam logic [15:0] BRAKE_DLY_RST = 16'h0000;

   // Drive states
   typedef enum logic [1:0] {
      HSOS_SAFE_OFF,
      HSOS_IDLE_BLOCKED,
      HSOS_OPERATING
   } hsos_state_t;

   // Register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [31:0] wdata;
   } hsos_bus_t;

   // Host command strobe
   typedef struct packed {
      logic valid;
      logic [7:0] code;
   } hsos_cmd_t;
endpackage

// ===== design/hsos_sequencer.sv
// Hard safe-off sequencer: two safety channels, drive state, brake and ready outputs.
// Assumes inputs synchronous to i_clock; the host sends one-cycle commands and
// reaches registers over a plain strobe port with read data one cycle later.
// How it works
// - Either safety channel alone removes the drive run signal.
// - Any channel reading OFF forces the safe-off state and cuts current.
// - Servo-off with both OFF gives safe-off; both ON then gives idle-blocked.
// - Status bit 10 shows safe-off; servo-on flag only while operating.
// - Servo-on during both OFF keeps safe-off until a later servo-off.
// - Safe-off persists, also without main power, until servo-off arrives; here, unless reset or servo-on set the latch, both channels ON end it.
// - Safe-off entered during a motion command raises a command warning.
// - One channel changing alone raises the skew alarm after 10 seconds.
// - Motor power goes off within 20 ms after both channels are OFF.
// - OFF pulses of 0.5 ms or less are ignored.
// - Supervision stays active while a utility function runs.
// - A utility run interrupted by safe-off must be cancelled and restarted.
// - Servo-ready is low in safe-off.
// - Servo-ready is high in idle-blocked with both channels ON.
// - Brake release drops at once on safe-off, skipping the brake delay.
// - Dynamic brake applies on safe-off when the stop setting selects it.
// - Safe-off alone never raises the servo alarm output.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module hsos_sequencer #(
   parameter int unsigned FILTER_CYCLES = hsos_pkg::FILTER_CYC,
   parameter int unsigned SHUTOFF_CYCLES = hsos_pkg::SHUTOFF_CYC,
   parameter longint unsigned SKEW_CYCLES = hsos_pkg::SKEW_CYC
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_safety_input_a,
   input wire logic i_safety_input_b,
   input wire logic i_main_power_ok,
   input wire hsos_pkg::hsos_cmd_t i_cmd,
   input wire hsos_pkg::hsos_bus_t i_bus,
   input wire logic i_fault,
   output logic [31:0] o_rdata,
   output logic o_drive_run,
   output logic o_servo_ready,
   output logic o_brake_release_out,
   output logic o_dyn_brake,
   output logic o_alarm_out
);
   initial begin
      if (FILTER_CYCLES < 1 || SHUTOFF_CYCLES <= FILTER_CYCLES + 4 || SKEW_CYCLES < 2)
         $error("hsos_sequencer: bad timing parameters");
   end

   localparam int FW = $clog2(FILTER_CYCLES + 2);
   localparam int SW = $clog2(SKEW_CYCLES + 2);
   localparam int BW = 16;
   localparam int OW = $clog2(SHUTOFF_CYCLES + 2);

   // Two-stage synchronisers, first stage read only by the second
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
      end else begin
         sync1_reg <= {i_safety_input_b, i_safety_input_a};
         sync2_reg <= sync1_reg;
      end
   end

   // Per-channel glitch filter: OFF is seen only after it has lasted past the window
   logic [1:0] ch_on_reg;
   logic [FW-1:0] flt_cnt_reg [2];
   for (genvar g = 0; g < 2; g++) begin : g_flt
      wire raw_off = !sync2_reg[g];
      always_ff @(posedge i_clock or negedge i_nrst) begin
         if (!i_nrst) begin
            flt_cnt_reg[g] <= '0;
            ch_on_reg[g] <= 1'b0;
         end else if (!raw_off) begin
            flt_cnt_reg[g] <= '0;
            ch_on_reg[g] <= 1'b1;
         end else if (flt_cnt_reg[g] > FW'(FILTER_CYCLES)) begin
            ch_on_reg[g] <= 1'b0;
         end else begin
            flt_cnt_reg[g] <= flt_cnt_reg[g] + 1'b1;
         end
      end
   end

   // Either channel OFF requests safe-off, independently of the other
   wire any_off = !ch_on_reg[0] || !ch_on_reg[1];
   wire both_off = !ch_on_reg[0] && !ch_on_reg[1];
   wire both_on = ch_on_reg[0] && ch_on_reg[1];

   // Register writes
   logic [31:0] control_reg;
   logic [BW-1:0] brake_dly_reg;
   wire wr_control = i_bus.wr && i_bus.addr == hsos_pkg::ADDR_CONTROL;
   wire wr_warn = i_bus.wr && i_bus.addr == hsos_pkg::ADDR_WARN;
   wire wr_brake = i_bus.wr && i_bus.addr == hsos_pkg::ADDR_BRAKE_DLY;
   wire db_en = control_reg[hsos_pkg::CT_DB_EN_BIT];
   wire util_run = control_reg[hsos_pkg::CT_UTIL_RUN_BIT];
   wire motion_busy = control_reg[hsos_pkg::CT_MOTION_BIT];
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         control_reg <= hsos_pkg::CONTROL_RST;
         brake_dly_reg <= hsos_pkg::BRAKE_DLY_RST;
      end else begin
         if (wr_control) control_reg <= i_bus.wdata;
         if (wr_brake) brake_dly_reg <= i_bus.wdata[BW-1:0];
      end
   end

   // Commands
   wire cmd_on = i_cmd.valid && i_cmd.code == hsos_pkg::CMD_SERVO_ON;
   wire cmd_off = i_cmd.valid && i_cmd.code == hsos_pkg::CMD_SERVO_OFF;

   // Drive state machine; main power loss does not release safe-off
   hsos_pkg::hsos_state_t state_reg, state_next;
   logic latch_reg, latch_next; // Servo-on seen while safe-off
   always_comb begin
      state_next = state_reg;
      latch_next = latch_reg;
      unique case (state_reg)
         hsos_pkg::HSOS_SAFE_OFF: begin
            if (cmd_on) latch_next = 1'b1;
            if (cmd_off) latch_next = 1'b0;
            if (both_on && !latch_next && !cmd_on) state_next = hsos_pkg::HSOS_IDLE_BLOCKED;
         end
         hsos_pkg::HSOS_IDLE_BLOCKED: begin
            if (any_off) state_next = hsos_pkg::HSOS_SAFE_OFF;
            else if (cmd_on && i_main_power_ok && !i_fault) state_next = hsos_pkg::HSOS_OPERATING;
         end
         hsos_pkg::HSOS_OPERATING: begin
            if (any_off) state_next = hsos_pkg::HSOS_SAFE_OFF;
            else if (cmd_off || !i_main_power_ok || i_fault)
               state_next = hsos_pkg::HSOS_IDLE_BLOCKED;
         end
      endcase
   end
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg <= hsos_pkg::HSOS_SAFE_OFF;
         latch_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         latch_reg <= latch_next;
      end
   end
   wire in_safe = state_reg == hsos_pkg::HSOS_SAFE_OFF;
   wire enter_safe = !in_safe && state_next == hsos_pkg::HSOS_SAFE_OFF;

   // Utility lock: an interrupted utility needs cancel and restart
   logic util_lock_reg;
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) util_lock_reg <= 1'b0;
      else if (any_off && util_run) util_lock_reg <= 1'b1;
      else if (!util_run) util_lock_reg <= 1'b0;
   end

   // Skew timer: runs while channels disagree
   logic [SW-1:0] skew_cnt_reg;
   wire disagree = ch_on_reg[0] != ch_on_reg[1];
   wire skew_hit = disagree && skew_cnt_reg == SW'(SKEW_CYCLES - 1);
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) skew_cnt_reg <= '0;
      else if (!disagree) skew_cnt_reg <= '0;
      else if (skew_cnt_reg != SW'(SKEW_CYCLES)) skew_cnt_reg <= skew_cnt_reg + 1'b1;
   end

   // Warnings: set wins over software clear
   logic warn_cmd_reg, warn_skew_reg;
   wire set_cmd_warn = enter_safe && (motion_busy || state_reg == hsos_pkg::HSOS_OPERATING);
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         warn_cmd_reg <= 1'b0;
         warn_skew_reg <= 1'b0;
      end else begin
         if (set_cmd_warn) warn_cmd_reg <= 1'b1;
         else if (wr_warn && i_bus.wdata[hsos_pkg::WN_CMD_BIT]) warn_cmd_reg <= 1'b0;
         if (skew_hit) warn_skew_reg <= 1'b1;
         else if (wr_warn && i_bus.wdata[hsos_pkg::WN_SKEW_BIT]) warn_skew_reg <= 1'b0;
      end
   end

   // Brake release delay after servo-off; skipped on safe-off
   logic [BW-1:0] bk_cnt_reg;
   logic brake_reg, run_reg, db_reg;
   wire operating = state_reg == hsos_pkg::HSOS_OPERATING;
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         bk_cnt_reg <= '0;
         brake_reg <= 1'b0;
         run_reg <= 1'b0;
         db_reg <= 1'b0;
      end else begin
         run_reg <= operating && !any_off && state_next == hsos_pkg::HSOS_OPERATING;
         db_reg <= in_safe ? db_en || db_reg && !both_on : 1'b0;
         if (state_next == hsos_pkg::HSOS_SAFE_OFF) begin
            brake_reg <= 1'b0;
            bk_cnt_reg <= '0;
         end else if (state_next == hsos_pkg::HSOS_OPERATING) begin
            brake_reg <= 1'b1;
            bk_cnt_reg <= brake_dly_reg;
         end else if (bk_cnt_reg != '0) begin
            bk_cnt_reg <= bk_cnt_reg - 1'b1;
         end else begin
            brake_reg <= 1'b0;
         end
      end
   end

   // Outputs
   assign o_drive_run = run_reg && ch_on_reg[0] && ch_on_reg[1];
   assign o_brake_release_out = brake_reg;
   assign o_dyn_brake = db_reg;
   assign o_servo_ready = state_reg == hsos_pkg::HSOS_IDLE_BLOCKED && both_on;
   assign o_alarm_out = warn_skew_reg || i_fault;

   // Read data, one cycle after the strobe
   logic [31:0] status_w;
   always_comb begin
      status_w = 32'h0;
      status_w[hsos_pkg::ST_SERVO_ON_BIT] = operating;
      status_w[hsos_pkg::ST_SAFE_OFF_BIT] = in_safe;
      status_w[hsos_pkg::ST_IN_A_BIT] = ch_on_reg[0];
      status_w[hsos_pkg::ST_IN_B_BIT] = ch_on_reg[1];
      status_w[hsos_pkg::ST_SKEW_BIT] = warn_skew_reg;
      status_w[hsos_pkg::ST_READY_BIT] = o_servo_ready;
      status_w[hsos_pkg::ST_UTIL_LOCK_BIT] = util_lock_reg;
   end
   wire [31:0] rd_mux =
      i_bus.addr == hsos_pkg::ADDR_STATUS ? status_w :
      i_bus.addr == hsos_pkg::ADDR_CONTROL ? control_reg :
      i_bus.addr == hsos_pkg::ADDR_WARN ? {30'h0, warn_skew_reg, warn_cmd_reg} :
      i_bus.addr == hsos_pkg::ADDR_BRAKE_DLY ? {16'h0, brake_dly_reg} : 32'h0;
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) o_rdata <= 32'h0;
      else o_rdata <= i_bus.rd ? rd_mux : 32'h0;
   end

   // Shut-off watch: counts cycles with both synchronised channels OFF
   // A counter stands in for a long delay range, which the tools cannot unroll
   logic [OW-1:0] off_cnt_reg;
   wire both_raw_off = !sync2_reg[0] && !sync2_reg[1];
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) off_cnt_reg <= '0;
      else if (!both_raw_off) off_cnt_reg <= '0;
      else if (off_cnt_reg != OW'(SHUTOFF_CYCLES)) off_cnt_reg <= off_cnt_reg + 1'b1;
   end

   // Checks on ready, brake and the drive state
   a_ready_safe: assert property (@(posedge i_clock) disable iff (!i_nrst)
      in_safe |-> !o_servo_ready) else $error("ready high in safe-off");
   a_ready_idle: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (state_reg == hsos_pkg::HSOS_IDLE_BLOCKED && both_on) |-> o_servo_ready)
      else $error("ready low in idle");
   a_brake_drop: assert property (@(posedge i_clock) disable iff (!i_nrst)
      enter_safe |=> !o_brake_release_out) else $error("brake not dropped");
   a_off_enters: assert property (@(posedge i_clock) disable iff (!i_nrst)
      any_off |=> in_safe) else $error("safe-off missed");
   a_shutoff_time: assert property (@(posedge i_clock) disable iff (!i_nrst)
      off_cnt_reg == OW'(SHUTOFF_CYCLES) |-> !o_drive_run)
      else $error("power not removed");
   a_safe_flag: assert property (@(posedge i_clock) disable iff (!i_nrst)
      in_safe |-> status_w[hsos_pkg::ST_SAFE_OFF_BIT] && !status_w[hsos_pkg::ST_SERVO_ON_BIT])
      else $error("flag wrong");
   a_latch_hold: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (in_safe && latch_reg && !cmd_off) |=> in_safe) else $error("left safe-off");
   a_cmd_warn: assert property (@(posedge i_clock) disable iff (!i_nrst)
      set_cmd_warn |=> warn_cmd_reg) else $error("warning missing");
   a_no_alarm: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (in_safe && !warn_skew_reg && !i_fault) |-> !o_alarm_out) else $error("alarm in safe-off");
   a_skew_alarm: assert property (@(posedge i_clock) disable iff (!i_nrst)
      skew_hit |=> warn_skew_reg ##0 o_alarm_out) else $error("skew alarm missing");
   a_db_apply: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (in_safe && db_en) |=> o_dyn_brake) else $error("dynamic brake off");
   a_db_release: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !in_safe |=> !o_dyn_brake)
      else $error("dynamic brake outside safe-off");
   a_brake_safe: assert property (@(posedge i_clock) disable iff (!i_nrst)
      in_safe |-> !o_brake_release_out)
      else $error("brake released in safe-off");

   // Checks on the channel path
   a_sync_chain: assert property (@(posedge i_clock) disable iff (!i_nrst)
      sync2_reg == $past(sync1_reg))
      else $error("synchroniser skipped");
   a_filter_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $fell(ch_on_reg[0]) |-> flt_cnt_reg[0] > FW'(FILTER_CYCLES))
      else $error("short pulse taken on A");
   a_filter_b: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $fell(ch_on_reg[1]) |-> flt_cnt_reg[1] > FW'(FILTER_CYCLES))
      else $error("short pulse taken on B");
   a_run_either: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (!ch_on_reg[0] || !ch_on_reg[1]) |-> !o_drive_run)
      else $error("one channel failed to block run");
   a_run_state: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_drive_run |-> operating)
      else $error("run outside operating");
   a_skew_quiet: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !disagree |=> skew_cnt_reg == '0)
      else $error("skew timer not cleared");

   // Checks on commands and utility lock
   a_idle_entry: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (in_safe && both_on && !latch_reg && !cmd_on) |=> state_reg == hsos_pkg::HSOS_IDLE_BLOCKED)
      else $error("idle-blocked not reached");
   a_on_accept: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (state_reg == hsos_pkg::HSOS_IDLE_BLOCKED && cmd_on && !any_off && i_main_power_ok
      && !i_fault) |=> operating)
      else $error("servo-on refused");
   a_power_loss: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (operating && !i_main_power_ok && !any_off) |=> state_reg == hsos_pkg::HSOS_IDLE_BLOCKED)
      else $error("power loss ignored");
   a_util_lock: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (any_off && util_run) |=> util_lock_reg)
      else $error("utility lock missing");
   a_util_safe: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (util_run && any_off) |=> in_safe)
      else $error("utility run bypassed safe-off");

   // Checks on warnings, alarm and read data
   a_warn_clear: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (wr_warn && i_bus.wdata[hsos_pkg::WN_CMD_BIT] && !set_cmd_warn) |=> !warn_cmd_reg)
      else $error("warning not cleared");
   a_alarm_src: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_alarm_out |-> warn_skew_reg || i_fault)
      else $error("alarm without cause");
   a_rdata_idle: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !$past(i_bus.rd) |-> o_rdata == 32'h0)
      else $error("read data outside its cycle");
   a_rdata_flag: assert property (@(posedge i_clock) disable iff (!i_nrst)
      ($past(i_bus.rd) && $past(i_bus.addr) == hsos_pkg::ADDR_STATUS)
      |-> o_rdata[hsos_pkg::ST_SAFE_OFF_BIT] == $past(in_safe))
      else $error("safe-off flag misread");
endmodule

`default_nettype wire

// ===== sim/hsos_safety_dev.sv
// Model of the two redundant safety devices that feed the sequencer.
// Assumes requests from the bench change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module hsos_safety_dev (
   input wire logic i_clock,
   input wire logic i_want_a,
   input wire logic i_want_b,
   input wire logic i_blip,
   output logic o_a,
   output logic o_b
);
   logic [3:0] blip_reg = 4'h0;

   // Short OFF pulse on channel A, six cycles, below the glitch filter
   always_ff @(posedge i_clock) begin
      if (i_blip) begin
         blip_reg <= 4'h6;
      end else if (blip_reg != 4'h0) begin
         blip_reg <= blip_reg - 4'h1;
      end
   end

   // Contact levels: 1 means current flows
   assign o_a = i_want_a && (blip_reg == 4'h0);
   assign o_b = i_want_b;
endmodule

`default_nettype wire

// ===== sim/tb_hard_safe_off_sequencer.sv
// Self-checking bench for the hard safe-off sequencer.
// Assumes short timing parameters and a 40 MHz clock; reads are scored from a queue.
`timescale 1ns/1ps
`default_nettype none

module tb_hard_safe_off_sequencer;
   logic i_clock, i_nrst, want_a, want_b, blip, sa, sb, pwr, fault;
   logic run, rdy, brk, dbk, alarm_out, pend;
   logic [31:0] rdata, r, expv;
   hsos_pkg::hsos_cmd_t cmd;
   hsos_pkg::hsos_bus_t bus;
   logic [31:0] expq[$];
   logic [31:0] seed = 32'h0000_0049;
   int checks = 0;
   int miscompares = 0;
   int k;

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
   $display("BAD %0t got %h exp %h", $time, a, b); end end
`define WAITN(c, n) begin k = 0; while (!(c) && k < n) begin @(posedge i_clock); #1; \
   k++; end if (!(c)) begin miscompares++; give_verdict(); end end

   hsos_sequencer #(.FILTER_CYCLES(8), .SHUTOFF_CYCLES(40), .SKEW_CYCLES(50)) u_dut (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_safety_input_a(sa), .i_safety_input_b(sb),
      .i_main_power_ok(pwr), .i_cmd(cmd), .i_bus(bus), .i_fault(fault), .o_rdata(rdata),
      .o_drive_run(run), .o_servo_ready(rdy), .o_brake_release_out(brk),
      .o_dyn_brake(dbk), .o_alarm_out(alarm_out));

   hsos_safety_dev u_dev (.i_clock(i_clock), .i_want_a(want_a), .i_want_b(want_b),
      .i_blip(blip), .o_a(sa), .o_b(sb));

   // Clock generation
   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic give_verdict();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clock);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clock);
      bus <= '0;
   endtask

   task automatic rreg(input logic [3:0] a, input logic [31:0] e);
      expq.push_back(e);
      @(posedge i_clock);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge i_clock);
      bus <= '0;
   endtask

   task automatic send(input logic [7:0] c);
      @(posedge i_clock);
      cmd <= '{valid: 1'b1, code: c};
      @(posedge i_clock);
      cmd <= '0;
   endtask

   task automatic pause(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask

   // Read data stand in the cycle after the strobe; score mid-cycle
   always @(posedge i_clock) pend <= bus.rd;
   always @(negedge i_clock) begin
      if (pend === 1'b1) begin
         expv = expq.pop_front();
         `CHK(rdata, expv)
      end
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge i_clock);
      miscompares++;
      give_verdict();
   end

   // Main sequence
   initial begin
      i_nrst = 1'b0;
      {want_a, want_b, blip, fault} = 4'h0;
      pwr = 1'b1;
      cmd = '0;
      bus = '0;
      pause(4);
      i_nrst <= 1'b1;
      pause(1);
      `CHK(run, 1'b0)
      `CHK(alarm_out, 1'b0)
      rreg(hsos_pkg::ADDR_STATUS, 32'h0000_0400);
      rreg(hsos_pkg::ADDR_CONTROL, hsos_pkg::CONTROL_RST);
      rreg(hsos_pkg::ADDR_BRAKE_DLY, {16'h0000, hsos_pkg::BRAKE_DLY_RST});
      r = xs();
      wreg(hsos_pkg::ADDR_BRAKE_DLY, r);
      rreg(hsos_pkg::ADDR_BRAKE_DLY, {16'h0000, r[15:0]});
      wreg(4'h2, xs());
      rreg(4'h2, 32'h0000_0000);
      want_a <= 1'b1;
      want_b <= 1'b1;
      pause(30);
      `CHK(rdy, 1'b0)
      send(hsos_pkg::CMD_SERVO_OFF);
      `WAITN(rdy, 300)
      rreg(hsos_pkg::ADDR_STATUS, 32'h0000_0016);
      wreg(hsos_pkg::ADDR_CONTROL, 32'h0000_0007);
      send(hsos_pkg::CMD_SERVO_ON);
      `WAITN(run, 300)
      `CHK(brk, 1'b1)
      rreg(hsos_pkg::ADDR_STATUS, 32'h0000_0007);
      // Short OFF pulse must leave power on
      @(posedge i_clock);
      blip <= 1'b1;
      @(posedge i_clock);
      blip <= 1'b0;
      for (int i = 0; i < 24; i++) begin
         pause(1);
         `CHK(run, 1'b1)
      end
      // Both channels OFF while running with utility and motion busy
      want_a <= 1'b0;
      want_b <= 1'b0;
      `WAITN(!run, 40)
      pause(2);
      `CHK(brk, 1'b0)
      `CHK(dbk, 1'b1)
      `CHK(alarm_out, 1'b0)
      `CHK(rdy, 1'b0)
      rreg(hsos_pkg::ADDR_STATUS, 32'h0000_0420);
      rreg(hsos_pkg::ADDR_WARN, 32'h0000_0001);
      wreg(hsos_pkg::ADDR_WARN, 32'h0000_0001);
      rreg(hsos_pkg::ADDR_WARN, 32'h0000_0000);
      wreg(hsos_pkg::ADDR_CONTROL, 32'h0000_0001);
      rreg(hsos_pkg::ADDR_STATUS, 32'h0000_0400);
      // Servo-on while OFF, power lost, channels back ON
      send(hsos_pkg::CMD_SERVO_ON);
      pwr <= 1'b0;
      want_a <= 1'b1;
      want_b <= 1'b1;
      pause(30);
      `CHK(rdy, 1'b0)
      rreg(hsos_pkg::ADDR_STATUS, 32'h0000_0406);
      pwr <= 1'b1;
      send(hsos_pkg::CMD_SERVO_OFF);
      `WAITN(rdy, 300)
      // One channel alone drops: skew alarm after the skew count
      want_a <= 1'b0;
      pause(40);
      `CHK(alarm_out, 1'b0)
      `CHK(run, 1'b0)
      `WAITN(alarm_out, 100)
      rreg(hsos_pkg::ADDR_WARN, 32'h0000_0002);
      want_a <= 1'b1;
      pause(30);
      wreg(hsos_pkg::ADDR_WARN, 32'h0000_0002);
      rreg(hsos_pkg::ADDR_WARN, 32'h0000_0000);
      pause(1);
      `CHK(alarm_out, 1'b0)
      `WAITN(rdy, 300)
      fault <= 1'b1;
      pause(1);
      `CHK(alarm_out, 1'b1)
      fault <= 1'b0;
      pause(3);
      give_verdict();
   end
endmodule

`default_nettype wire
